/* design/gfm_top.sv */
// Pin function mux with central interrupt mask, reached over AXI4-Lite
`timescale 1ns/10ps
// How it works
// - Mask bit set blocks source; reset unmasked
// - Source needs its own enable too
// - Bits 15:8 sync events, 11 reserved, 7:0 PHY
// - Four-bit field per pin, four per register
// - Media interface claims pins over setting
// - Lamp functions drive the pin active low
// - Writing 0000 keeps the pin's function
// - 0001-0100 select pulse-per-second and pulse units
// - 0111-1100 link, fast, activity lamps
// - 1101 interrupt, 1110 chip sync, 1111 input
// - Pin 2 packet strobes use PHY B
// - Pin 7 receive bit 3 in MII
// - Pin 6 carrier valid in RMII, 1110 carrier
// - Pins 5,4: 1110 collision B and A
// - Status sets if enabled; clears on read
module gfm_top (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] irq_event,
  input  wire logic [15:0] irq_source_enable,
  input  wire logic        rmii_mode,
  input  wire logic        pps_out,
  input  wire logic        pulse_unit_one_out,
  input  wire logic        pulse_unit_two_out,
  input  wire logic        pulse_unit_three_out,
  input  wire logic [1:0]  sync_enable,
  input  wire logic [1:0]  sync_tx_strobe,
  input  wire logic [1:0]  sync_rx_strobe,
  input  wire logic [1:0]  frame_tx_start,
  input  wire logic [1:0]  frame_rx_start,
  input  wire logic        link_lamp_a,
  input  wire logic        link_lamp_b,
  input  wire logic        fast_lamp_a,
  input  wire logic        fast_lamp_b,
  input  wire logic        activity_lamp_a,
  input  wire logic        activity_lamp_b,
  input  wire logic        chip_sync,
  input  wire logic        collision_a,
  input  wire logic        collision_b,
  input  wire logic        carrier_sense_a,
  input  wire logic        carrier_valid_a,
  input  wire logic        rx_data_bit3_a,
  input  wire logic [7:0]  pin_in,
  output logic [7:0]       pin_out,
  output logic [7:0]       pin_oe_n,
  output logic [7:0]       pin_in_seen,
  output logic             irq
);

  logic [15:0] interrupt_mask;
  logic [15:0] irq_status;
  logic [15:0] pin_function_select_a;
  logic [15:0] pin_function_select_b;
  logic [3:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic        wr_fire;
  logic        rd_fire;
  logic        status_read;
  logic [15:0] status_set;
  logic [7:0]  next_pin_out;
  logic [7:0]  next_pin_oe_n;
  logic        resp_wait;

  // Merge a written select word: bytes gated by strobes, code 0000 keeps the field
  function automatic logic [15:0] merge_sel(input logic [15:0] cur, input logic [31:0] wd,
                                            input logic [3:0] strb);
    logic [15:0] res;
    res = cur;
    for (int i = 0; i < 4; i++) begin
      if (strb[i / 2] && wd[i * 4 +: 4] != gfm_pkg::GFM_FN_KEEP) begin
        res[i * 4 +: 4] = wd[i * 4 +: 4];
      end
    end
    return res;
  endfunction

  // Central summary: a status bit raises the line only while its mask bit is clear
  function automatic logic irq_pending(input logic [15:0] status, input logic [15:0] mask);
    return |(status & ~mask);
  endfunction

  // The status word is read-only, so only the other three accept a write
  function automatic logic wr_mapped(input logic [3:0] addr);
    return addr == gfm_pkg::OFF_MASK || addr == gfm_pkg::OFF_SEL_A ||
           addr == gfm_pkg::OFF_SEL_B;
  endfunction

  function automatic logic rd_mapped(input logic [3:0] addr);
    return wr_mapped(addr) || addr == gfm_pkg::OFF_STATUS;
  endfunction

  // Packet strobe while time sync runs on that PHY, otherwise any frame start
  function automatic logic packet_level(input logic sync_on, input logic sync_strobe,
                                        input logic frame_start);
    return sync_on ? sync_strobe : frame_start;
  endfunction

  // Lamps sink current: the pin goes low to light the lamp
  function automatic logic lamp_level(input logic lit);
    return !lit;
  endfunction

  // Four fields per register: pins 3:0 in the first, pins 7:4 in the second
  function automatic logic [3:0] field_code(input int pin, input logic [15:0] sel_lo,
                                            input logic [15:0] sel_hi);
    logic [3:0] res;
    if (pin < 4) begin
      res = sel_lo[pin * 4 +: 4];
    end else begin
      res = sel_hi[(pin - 4) * 4 +: 4];
    end
    return res;
  endfunction

  // Code 1110 differs per pin: collisions on 4 and 5, carrier sense on 6, chip sync elsewhere
  function automatic logic special_level(input int pin, input logic col_a, input logic col_b,
                                         input logic sense_a, input logic sync_out);
    logic res;
    unique case (pin)
      4:       res = col_a;
      5:       res = col_b;
      6:       res = sense_a;
      default: res = sync_out;
    endcase
    return res;
  endfunction

  // Write channel: address and data taken independently, response after both
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  // Data may arrive before or after its address; each is held until both are in
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  // Readies stay low while a response waits, so a new write cannot pile up behind it
  assign resp_wait = s_axi_bvalid && !s_axi_bready;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !resp_wait;
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !resp_wait;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Unmapped writes are dropped and answered with an error
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_bresp <= gfm_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bresp <= wr_mapped(aw_addr) ? gfm_pkg::RESP_OKAY : gfm_pkg::RESP_SLVERR;
    end
  end

  // Reserved bit 11 reads back as zero whatever is written
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      interrupt_mask <= gfm_pkg::MASK_RST;
    end else if (wr_fire && aw_addr == gfm_pkg::OFF_MASK) begin
      if (w_strb[0]) begin
        interrupt_mask[7:0] <= w_data[7:0];
      end
      if (w_strb[1]) begin
        interrupt_mask[15:8] <= w_data[15:8];
      end
      interrupt_mask[gfm_pkg::RSV_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_function_select_a <= gfm_pkg::SEL_A_RST;
    end else if (wr_fire && aw_addr == gfm_pkg::OFF_SEL_A) begin
      pin_function_select_a <= merge_sel(pin_function_select_a, w_data, w_strb);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_function_select_b <= gfm_pkg::SEL_B_RST;
    end else if (wr_fire && aw_addr == gfm_pkg::OFF_SEL_B) begin
      pin_function_select_b <= merge_sel(pin_function_select_b, w_data, w_strb);
    end
  end

  // Read channel: one cycle after the address is taken
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign status_read = rd_fire && s_axi_araddr == gfm_pkg::OFF_STATUS;

  // One read in flight: the address is refused until its data has been taken
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= gfm_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= rd_mapped(s_axi_araddr) ? gfm_pkg::RESP_OKAY : gfm_pkg::RESP_SLVERR;
      // A status read returns the word as it stood before this cycle's clear
      unique case (s_axi_araddr)
        gfm_pkg::OFF_STATUS: s_axi_rdata <= {16'h0000, irq_status};
        gfm_pkg::OFF_MASK:   s_axi_rdata <= {16'h0000, interrupt_mask};
        gfm_pkg::OFF_SEL_A:  s_axi_rdata <= {16'h0000, pin_function_select_a};
        gfm_pkg::OFF_SEL_B:  s_axi_rdata <= {16'h0000, pin_function_select_b};
        default:             s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Reserved bit never latches; source enable gates before the summary
  assign status_set = irq_event & irq_source_enable
                      & ~(16'h0001 << gfm_pkg::RSV_BIT);

  // Set wins over a same-cycle clear-on-read so no event is lost
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_status <= gfm_pkg::STATUS_RST;
    end else begin
      irq_status <= (status_read ? 16'h0000 : irq_status) | status_set;
    end
  end

  // Registered so the line cannot glitch while status and mask change together
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_pending(irq_status, interrupt_mask);
    end
  end

  // Pin drive decode
  always_comb begin
    logic [3:0] code;
    logic       drv;
    logic       val;
    logic       phy;
    code = 4'h0;
    drv = 1'b0;
    val = 1'b0;
    phy = 1'b0;
    next_pin_out = 8'h00;
    next_pin_oe_n = 8'hff;
    for (int p = 0; p < gfm_pkg::NUM_PINS; p++) begin
      code = field_code(p, pin_function_select_a, pin_function_select_b);
      // Pin 2 alone takes its packet strobes from PHY B
      phy = (p == 2);
      drv = 1'b1;
      val = 1'b0;
      unique case (gfm_pkg::gfm_fn_t'(code))
        gfm_pkg::GFM_FN_PPS:     val = pps_out;
        gfm_pkg::GFM_FN_PULSE1:  val = pulse_unit_one_out;
        gfm_pkg::GFM_FN_PULSE2:  val = pulse_unit_two_out;
        gfm_pkg::GFM_FN_PULSE3:  val = pulse_unit_three_out;
        gfm_pkg::GFM_FN_TX_PKT:  val = packet_level(sync_enable[phy], sync_tx_strobe[phy],
                                                    frame_tx_start[phy]);
        gfm_pkg::GFM_FN_RX_PKT:  val = packet_level(sync_enable[phy], sync_rx_strobe[phy],
                                                    frame_rx_start[phy]);
        gfm_pkg::GFM_FN_LINK_A:  val = lamp_level(link_lamp_a);
        gfm_pkg::GFM_FN_LINK_B:  val = lamp_level(link_lamp_b);
        gfm_pkg::GFM_FN_FAST_A:  val = lamp_level(fast_lamp_a);
        gfm_pkg::GFM_FN_FAST_B:  val = lamp_level(fast_lamp_b);
        gfm_pkg::GFM_FN_ACT_A:   val = lamp_level(activity_lamp_a);
        gfm_pkg::GFM_FN_ACT_B:   val = lamp_level(activity_lamp_b);
        gfm_pkg::GFM_FN_IRQ:     val = irq_pending(irq_status, interrupt_mask);
        gfm_pkg::GFM_FN_SPECIAL: val = special_level(p, collision_a, collision_b,
                                                     carrier_sense_a, chip_sync);
        gfm_pkg::GFM_FN_INPUT:   drv = 1'b0;
        // No field can hold 0000 (reset values have none and writes skip it): leave the pin released
        default:                 drv = 1'b0;
      endcase
      // Media interface claims override the select field
      if (p == 7 && !rmii_mode) begin
        drv = 1'b1;
        val = rx_data_bit3_a;
      end
      if (p == 6 && rmii_mode) begin
        drv = 1'b1;
        val = carrier_valid_a;
      end
      next_pin_out[p] = drv ? val : 1'b0;
      next_pin_oe_n[p] = !drv;
    end
  end

  // Registered so a select write never glitches a pin
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_out <= 8'h00;
      pin_oe_n <= 8'hff;
    end else begin
      pin_out <= next_pin_out;
      pin_oe_n <= next_pin_oe_n;
    end
  end

  // Only released pins are reported, so a driven pin never reads back its own output
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_in_seen <= 8'h00;
    end else begin
      pin_in_seen <= pin_in & next_pin_oe_n;
    end
  end
endmodule

/* design/gfm_pkg.sv */
// Package: register map, field layout, reset values and pin function codes of the pin mux
package gfm_pkg;
  localparam logic [3:0]  ADDR_W          = 4'd4;
  localparam logic [3:0]  OFF_STATUS      = 4'h0;
  localparam logic [3:0]  OFF_MASK        = 4'h4;
  localparam logic [3:0]  OFF_SEL_A       = 4'h8;
  localparam logic [3:0]  OFF_SEL_B       = 4'hc;
  localparam logic [15:0] MASK_RST        = 16'h0000;
  localparam logic [15:0] STATUS_RST      = 16'h0000;
  localparam logic [15:0] SEL_A_RST       = 16'hc8b7;
  // Pin 7 resets to chip sync; pin 6 to link lamp A; pins 5 and 4 to fast lamps
  localparam logic [15:0] SEL_B_RST       = 16'he7a9;
  localparam int          RSV_BIT         = 11;
  localparam int          FIELD_W         = 4;
  localparam int          NUM_PINS        = 8;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

  typedef enum logic [3:0] {
    GFM_FN_KEEP      = 4'b0000,
    GFM_FN_PPS       = 4'b0001,
    GFM_FN_PULSE1    = 4'b0010,
    GFM_FN_PULSE2    = 4'b0011,
    GFM_FN_PULSE3    = 4'b0100,
    GFM_FN_TX_PKT    = 4'b0101,
    GFM_FN_RX_PKT    = 4'b0110,
    GFM_FN_LINK_A    = 4'b0111,
    GFM_FN_LINK_B    = 4'b1000,
    GFM_FN_FAST_A    = 4'b1001,
    GFM_FN_FAST_B    = 4'b1010,
    GFM_FN_ACT_A     = 4'b1011,
    GFM_FN_ACT_B     = 4'b1100,
    GFM_FN_IRQ       = 4'b1101,
    GFM_FN_SPECIAL   = 4'b1110,
    GFM_FN_INPUT     = 4'b1111
  } gfm_fn_t;
endpackage

/* bench/gfm_top_sva.sv */
// Checker: bus answer timing, interrupt cause and pin driver relations of the pin mux
`timescale 1ns/10ps
module gfm_top_sva (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        irq,
  input wire logic [15:0] irq_event,
  input wire logic [15:0] irq_source_enable,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe_n,
  input wire logic [7:0]  pin_in_seen
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  // A mask write may also be what lets a pending status bit through
  wire logic cause = (|(irq_event & irq_source_enable)) || s_axi_awvalid;

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_reset_quiet: assert property (disable iff (1'b0) srst |=>
    !irq && pin_oe_n == 8'hff && !s_axi_bvalid && !s_axi_rvalid) else $error("active in reset");
  a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("late bvalid");
  a_read_answer: assert property (rd_taken |=> s_axi_rvalid) else $error("late rvalid");
  a_resp_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid kept");
  a_ready_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready while pending");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_irq_cause: assert property ($rose(irq) |->
    $past(cause, 2) || $past(cause, 3) || $past(cause, 4)) else $error("irq without cause");
  a_idle_low: assert property ((pin_out & pin_oe_n) == 8'h00)
    else $error("released pin shows 1");
  a_seen_masked: assert property ((pin_in_seen & ~pin_oe_n) == 8'h00)
    else $error("driven pin seen as input");
endmodule

bind gfm_top gfm_top_sva u_sva (.sys_clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rdata, .irq, .irq_event, .irq_source_enable, .pin_out, .pin_oe_n, .pin_in_seen);

/* bench/tb_gfm_top.sv */
// Testbench: register access, pin function decode and interrupt path of the pin mux
`timescale 1ns/10ps
module tb_gfm_top;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, rmii = 1;
  logic [31:0] wdata = 32'h0;
  logic [15:0] ev = 16'h0, en = 16'h0, fs = 16'h5a3c;
  logic [9:0]  pk = 10'h1a7;
  logic [7:0]  pin_in = 8'h96;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [7:0]  pout, poe, pseen;
  int          n_mismatch = 0, total_checks = 0;

  always #50 sys_clk = ~sys_clk;

  gfm_top u_dut (.sys_clk(sys_clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq_event(ev), .irq_source_enable(en), .rmii_mode(rmii), .pps_out(fs[1]),
    .pulse_unit_one_out(fs[2]), .pulse_unit_two_out(fs[3]), .pulse_unit_three_out(fs[4]),
    .sync_enable(pk[1:0]), .sync_tx_strobe(pk[3:2]), .sync_rx_strobe(pk[5:4]),
    .frame_tx_start(pk[7:6]), .frame_rx_start(pk[9:8]), .link_lamp_a(fs[7]),
    .link_lamp_b(fs[8]), .fast_lamp_a(fs[9]), .fast_lamp_b(fs[10]), .activity_lamp_a(fs[11]),
    .activity_lamp_b(fs[12]), .chip_sync(fs[14]), .collision_a(fs[0]), .collision_b(fs[13]),
    .carrier_sense_a(fs[15]), .carrier_valid_a(fs[5]), .rx_data_bit3_a(fs[6]),
    .pin_in(pin_in), .pin_out(pout), .pin_oe_n(poe), .pin_in_seen(pseen), .irq(irq));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data are offered together; each is dropped once its own ready is seen
  task wr(input logic [3:0] a, input logic [15:0] v);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {16'h0000, v};
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      ad = ad | awready;
      dd = dd | wready;
    end
    do @(posedge sys_clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [3:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task pulse(input logic [15:0] v);
    @(posedge sys_clk);
    ev <= v;
    @(posedge sys_clk);
    ev <= 16'h0;
  endtask

  // Expected level of a pin decoding like pin 0, packet strobes taken from PHY p
  function automatic logic e0(input logic [3:0] c, input int p);
    case (c)
      4'h5: e0 = pk[p] ? pk[2+p] : pk[6+p];
      4'h6: e0 = pk[p] ? pk[4+p] : pk[8+p];
      4'hd: e0 = 1'b0;
      4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc: e0 = ~fs[c];
      default: e0 = fs[c];
    endcase
  endfunction

  task summarize;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #(100 * 5000);
    n_mismatch++;
    summarize;
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    cyc(3);
    rd(gfm_pkg::OFF_MASK);
    chk(d, 32'h0);
    rd(gfm_pkg::OFF_SEL_A);
    chk(d, 32'hc8b7);
    rd(gfm_pkg::OFF_SEL_B);
    chk(d, 32'he7a9);
    chk(pout, {fs[14], fs[5], ~fs[10], ~fs[9], ~fs[12], ~fs[8], ~fs[11], ~fs[7]});
    chk(poe, 8'h00);
    for (int s = 0; s < 2; s++) begin
      fs <= s ? 16'ha5c3 : 16'h5a3c;
      pk <= s ? 10'h258 : 10'h1a7;
      for (int c = 1; c < 15; c++) begin
        wr(gfm_pkg::OFF_SEL_A, {4'hf, c[3:0], 4'hf, c[3:0]});
        cyc(3);
        chk({poe[2], poe[0], pout[2], pout[0]}, {2'b00, e0(c[3:0], 1), e0(c[3:0], 0)});
      end
    end
    chk({poe[1], pout[1], pseen[1]}, {2'b10, pin_in[1]});
    wr(gfm_pkg::OFF_SEL_A, 16'h0000);
    chk(r, 2'b00);
    rd(gfm_pkg::OFF_SEL_A);
    chk(d, 32'hfefe);
    rmii <= 1'b0;
    wr(gfm_pkg::OFF_SEL_B, 16'h0eee);
    cyc(3);
    chk({poe[7:4], pout[7:4]}, {4'h0, fs[6], fs[15], fs[13], fs[0]});
    rmii <= 1'b1;
    cyc(3);
    chk(pout[7:6], {fs[14], fs[5]});
    en <= 16'h0008;
    pulse(16'h0088);
    cyc(3);
    chk(irq, 1'b1);
    rd(gfm_pkg::OFF_STATUS);
    chk(d, 32'h8);
    cyc(2);
    chk(irq, 1'b0);
    wr(gfm_pkg::OFF_MASK, 16'hffff);
    rd(gfm_pkg::OFF_MASK);
    chk(d, 32'hf7ff);
    pulse(16'h0008);
    cyc(3);
    chk(irq, 1'b0);
    wr(gfm_pkg::OFF_SEL_A, 16'h000d);
    wr(gfm_pkg::OFF_MASK, 16'h0000);
    cyc(3);
    chk({irq, pout[0]}, 2'b11);
    rd(gfm_pkg::OFF_STATUS);
    chk(d, 32'h8);
    cyc(3);
    chk({irq, pout[0]}, 2'b00);
    rd(4'h2);
    chk(r, 2'b10);
    chk(d, 32'h0);
    summarize;
  end
endmodule
